// >>> common/sfr_pkg.sv
/*
 * Constants, opcodes and types for the serial flash read path.
 * Assumes one MCLK domain; the link pins are synchronised before use.
 */
package sfr_pkg;
    // Line-width codes: bits per edge is 1 << code
    localparam logic [1:0] LW_1 = 2'h0;
    localparam logic [1:0] LW_2 = 2'h1;
    localparam logic [1:0] LW_4 = 2'h2;

    localparam logic [3:0] OE_X1 = 4'h2;
    localparam logic [3:0] OE_X2 = 4'h3;
    localparam logic [3:0] OE_X4 = 4'hf;

    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DOUT = 8'h3b;
    localparam logic [7:0] OP_DIO = 8'hbb;
    localparam logic [7:0] OP_QOUT = 8'h6b;
    localparam logic [7:0] OP_QIO = 8'heb;
    localparam logic [7:0] OP_DTR_FAST = 8'h0d;
    localparam logic [7:0] OP_DTR_DOUT = 8'h3d;
    localparam logic [7:0] OP_DTR_DIO = 8'hbd;
    localparam logic [7:0] OP_DTR_QOUT = 8'h6d;
    localparam logic [7:0] OP_DTR_QIO = 8'hed;
    localparam logic [7:0] OP_QWORD = 8'he7;
    localparam logic [7:0] OP_READ4 = 8'h13;
    localparam logic [7:0] OP_FAST4 = 8'h0c;
    localparam logic [7:0] OP_DOUT4 = 8'h3c;
    localparam logic [7:0] OP_DIO4 = 8'hbc;
    localparam logic [7:0] OP_QOUT4 = 8'h6c;
    localparam logic [7:0] OP_QIO4 = 8'hec;
    localparam logic [7:0] OP_DTR_FAST4 = 8'h0e;
    localparam logic [7:0] OP_DTR_DIO4 = 8'hbe;
    localparam logic [7:0] OP_DTR_QIO4 = 8'hee;

    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ADDR3_BITS = 6'h18;
    localparam logic [5:0] ADDR4_BITS = 6'h20;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] DUMMY_DEF = 4'h8;
    localparam logic [3:0] DUMMY_WORD = 4'h4;
    localparam logic [3:0] DUMMY_USE_DEF = 4'h0;

    typedef struct packed {
        logic ok;
        logic a4;
        logic dtr;
        logic fast;
        logic word;
        logic [1:0] aw;
        logic [1:0] dw;
    } sfr_cmd_s;

    typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_SKIP} sfr_phase_e;
endpackage

// >>> design/sfr_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes each bit is a slow level; bundles are not coherent across bits.
 */
`timescale 1ns/10ps
module sfr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> design/sfr_mem.sv
/*
 * Byte array with a registered read port and a simple write port.
 * Assumes read address may change every cycle; data follow one cycle later.
 */
`timescale 1ns/10ps
module sfr_mem #(
    parameter int AW = 10
) (
    // Clock
    input wire logic clk,
    // Fill port
    input wire logic we,
    input wire logic [AW-1:0] wa,
    input wire logic [7:0] wd,
    // Read port
    input wire logic [AW-1:0] ra,
    output logic [7:0] q
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    always_ff @(posedge clk) begin
        q <= mem[ra];
    end
endmodule

// >>> design/sfr_read_engine.sv
/*
 * Serial flash array read engine: command decode, address capture,
 * dummy count and streamed data output at single or double rate.
 * Assumes SCK idles low between frames and is slow against MCLK
 * (at least a dozen MCLK per SCK period); config inputs are MCLK-domain.
 */
// Functional notes
// RULE1: host opens with chip-select, command, address
// RULE2: chip-select high aborts read, releases lines
// RULE3: three address bytes by default
// RULE4: address bits taken on rising clock
// RULE5: start anywhere, address steps each byte
// RULE6: wrap to zero past last address
// RULE7: 03h plain read, 0Bh fast read
// RULE8: 3Bh dual output, BBh dual address/data
// RULE9: 6Bh quad output, EBh quad address/data
// RULE10: 0Dh, 3Dh, BDh double-rate reads
// RULE11: 6Dh, EDh double-rate quad reads
// RULE12: double-rate opcodes always double rate
// RULE13: E7h even address, four dummy clocks
// RULE14: E7h only single-rate extended or quad
// RULE15: four-byte opcodes take 32-bit address
// RULE16: 13h plain, 0Ch fast four-byte reads
// RULE17: 3Ch, BCh dual four-byte reads
// RULE18: 6Ch, ECh quad four-byte reads
// RULE19: 0Eh, BEh, EEh double-rate four-byte reads
// RULE20: address mode from config or commands
// RULE21: four-byte opcodes force 32-bit address
// RULE22: command width follows protocol lines
// RULE23: four-byte mode lengthens standard reads
// RULE24: fast-read dummy count from configuration
// RULE25: lines released unless sending data
`timescale 1ns/10ps
module sfr_read_engine #(
    parameter int MEM_AW = 10
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Serial link
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic [3:0] DQ_IN,
    output logic [3:0] DQ_OUT,
    output logic [3:0] DQ_OE,
    // Configuration
    input wire logic [1:0] PROTO,
    input wire logic DTR_ENABLE,
    input wire logic ADDR4_NV,
    input wire logic ENTER_4B,
    input wire logic EXIT_4B,
    input wire logic [3:0] DUMMY_CFG,
    output logic ADDR4_ACTIVE,
    // Array fill
    input wire logic FILL_EN,
    input wire logic [MEM_AW-1:0] FILL_ADDR,
    input wire logic [7:0] FILL_DATA
);
    import sfr_pkg::*;

    logic sck_s;
    logic cs_n_s;
    logic [3:0] dq_s;
    logic sck_d;
    logic rise;
    logic fall;
    sfr_phase_e phase;
    logic [5:0] cnt;
    logic [31:0] sh;
    sfr_cmd_s cmd;
    logic dtr;
    logic [1:0] aw;
    logic [1:0] dw;
    logic [3:0] dum;
    logic [MEM_AW-1:0] idx;
    logic [7:0] obyte;
    logic [3:0] obits;
    logic started;
    logic addr_go;
    logic mode4;
    logic mode4_init;
    logic [7:0] mem_q;

    logic [1:0] wcode;
    logic samp;
    logic [5:0] step;
    logic [3:0] ostep;
    logic [31:0] next_sh;
    sfr_cmd_s dec;
    logic dec_ok;
    logic [3:0] next_dum;
    logic cmd_done;
    logic addr_done;
    logic out_edge;
    logic byte_load;
    logic [7:0] src;

    function automatic sfr_cmd_s mk(input logic a4, input logic dt, input logic fa,
                                    input logic wo, input logic [1:0] a, input logic [1:0] d);
        return {1'b1, a4, dt, fa, wo, a, d};
    endfunction

    function automatic sfr_cmd_s decode(input logic [7:0] op);
        sfr_cmd_s c;
        c = '0;
        case (op)
            OP_READ: c = mk(1'b0, 1'b0, 1'b0, 1'b0, LW_1, LW_1); // [RULE7]
            OP_FAST: c = mk(1'b0, 1'b0, 1'b1, 1'b0, LW_1, LW_1); // [RULE7]
            OP_DOUT: c = mk(1'b0, 1'b0, 1'b1, 1'b0, LW_1, LW_2); // [RULE8]
            OP_DIO: c = mk(1'b0, 1'b0, 1'b1, 1'b0, LW_2, LW_2); // [RULE8]
            OP_QOUT: c = mk(1'b0, 1'b0, 1'b1, 1'b0, LW_1, LW_4); // [RULE9]
            OP_QIO: c = mk(1'b0, 1'b0, 1'b1, 1'b0, LW_4, LW_4); // [RULE9]
            OP_DTR_FAST: c = mk(1'b0, 1'b1, 1'b1, 1'b0, LW_1, LW_1); // [RULE10]
            OP_DTR_DOUT: c = mk(1'b0, 1'b1, 1'b1, 1'b0, LW_1, LW_2); // [RULE10]
            OP_DTR_DIO: c = mk(1'b0, 1'b1, 1'b1, 1'b0, LW_2, LW_2); // [RULE10]
            OP_DTR_QOUT: c = mk(1'b0, 1'b1, 1'b1, 1'b0, LW_1, LW_4); // [RULE11]
            OP_DTR_QIO: c = mk(1'b0, 1'b1, 1'b1, 1'b0, LW_4, LW_4); // [RULE11]
            OP_QWORD: c = mk(1'b0, 1'b0, 1'b1, 1'b1, LW_4, LW_4); // [RULE13]
            OP_READ4: c = mk(1'b1, 1'b0, 1'b0, 1'b0, LW_1, LW_1); // [RULE16]
            OP_FAST4: c = mk(1'b1, 1'b0, 1'b1, 1'b0, LW_1, LW_1); // [RULE16]
            OP_DOUT4: c = mk(1'b1, 1'b0, 1'b1, 1'b0, LW_1, LW_2); // [RULE17]
            OP_DIO4: c = mk(1'b1, 1'b0, 1'b1, 1'b0, LW_2, LW_2); // [RULE17]
            OP_QOUT4: c = mk(1'b1, 1'b0, 1'b1, 1'b0, LW_1, LW_4); // [RULE18]
            OP_QIO4: c = mk(1'b1, 1'b0, 1'b1, 1'b0, LW_4, LW_4); // [RULE18]
            OP_DTR_FAST4: c = mk(1'b1, 1'b1, 1'b1, 1'b0, LW_1, LW_1); // [RULE19]
            OP_DTR_DIO4: c = mk(1'b1, 1'b1, 1'b1, 1'b0, LW_2, LW_2); // [RULE19]
            OP_DTR_QIO4: c = mk(1'b1, 1'b1, 1'b1, 1'b0, LW_4, LW_4); // [RULE19]
            default: c = '0;
        endcase
        return c;
    endfunction

    function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] d,
                                             input logic [1:0] w);
        case (w)
            LW_2: return {s[29:0], d[1:0]};
            LW_4: return {s[27:0], d};
            default: return {s[30:0], d[0]};
        endcase
    endfunction

    function automatic logic [3:0] place(input logic [7:0] b, input logic [1:0] w);
        case (w)
            LW_2: return {2'h0, b[7:6]};
            LW_4: return b[7:4];
            default: return {2'h0, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] oe_mask(input logic [1:0] w);
        case (w)
            LW_2: return OE_X2;
            LW_4: return OE_X4;
            default: return OE_X1;
        endcase
    endfunction

    function automatic logic [1:0] wider(input logic [1:0] a, input logic [1:0] b);
        return (a > b) ? a : b;
    endfunction

    sfr_sync #(
        .W(6),
        .INIT(6'h10)
    ) u_sync (
        .clk(MCLK),
        .rst_n(RESETN),
        .d({SCK, CS_N, DQ_IN}),
        .q({sck_s, cs_n_s, dq_s})
    );

    sfr_mem #(
        .AW(MEM_AW)
    ) u_mem (
        .clk(MCLK),
        .we(FILL_EN),
        .wa(FILL_ADDR),
        .wd(FILL_DATA),
        .ra(idx),
        .q(mem_q)
    );

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= sck_s;
        end
    end

    assign rise = sck_s & ~sck_d;
    assign fall = ~sck_s & sck_d;

    always_comb begin
        // Command rides the protocol's own lines; address may be wider
        wcode = (phase == PH_CMD) ? PROTO : aw; // [RULE22]
        // Double-rate address opens on a rise, never on the command's trailing fall
        samp = rise | (fall & ((phase == PH_CMD) ? DTR_ENABLE : (dtr & addr_go))); // [RULE4]
        step = 6'h01 << wcode;
        ostep = 4'h1 << dw;
        next_sh = shift_in(sh, dq_s, wcode);
        dec = decode(next_sh[7:0]);
        // Word read refused in dual protocol and at double rate
        dec_ok = dec.ok && !(dec.word && (PROTO == LW_2 || DTR_ENABLE)); // [RULE14]
        if (dec.word) begin
            next_dum = DUMMY_WORD; // [RULE13]
        end else if (!dec.fast) begin
            next_dum = '0;
        end else if (DUMMY_CFG == DUMMY_USE_DEF) begin
            next_dum = DUMMY_DEF; // [RULE24]
        end else begin
            next_dum = DUMMY_CFG; // [RULE24]
        end
        cmd_done = phase == PH_CMD && samp && cnt == step;
        addr_done = phase == PH_ADDR && samp && cnt == step;
        out_edge = phase == PH_DATA && (fall || (dtr && rise && started));
        byte_load = out_edge && obits == 4'h0;
        src = (obits == 4'h0) ? mem_q : obyte;
    end

    // Address mode: strap caught once after release, then commands rule
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            mode4 <= 1'b0;
            mode4_init <= 1'b0;
        end else if (!mode4_init) begin
            mode4_init <= 1'b1;
            mode4 <= ADDR4_NV; // [RULE20]
        end else if (ENTER_4B) begin
            mode4 <= 1'b1; // [RULE20]
        end else if (EXIT_4B) begin
            mode4 <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ADDR4_ACTIVE <= 1'b0;
        end else begin
            ADDR4_ACTIVE <= mode4;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sh <= '0;
        end else if (cs_n_s) begin
            sh <= '0;
        end else if (samp && (phase == PH_CMD || phase == PH_ADDR)) begin
            sh <= next_sh; // [RULE4]
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            phase <= PH_IDLE;
            cnt <= '0;
            cmd <= '0;
            dtr <= 1'b0;
            aw <= LW_1;
            dw <= LW_1;
            dum <= '0;
            addr_go <= 1'b0;
        end else if (cs_n_s) begin
            phase <= PH_IDLE; // [RULE2]
        end else begin
            unique case (phase)
                PH_IDLE: begin
                    phase <= PH_CMD; // [RULE1]
                    cnt <= CMD_BITS;
                end
                PH_CMD: begin
                    if (samp) begin
                        cnt <= cnt - step;
                    end
                    if (cmd_done && dec_ok) begin
                        phase <= PH_ADDR;
                        // [RULE3] [RULE15] [RULE21] [RULE23]
                        cnt <= (dec.a4 || mode4) ? ADDR4_BITS : ADDR3_BITS;
                        cmd <= dec;
                        dtr <= dec.dtr | DTR_ENABLE; // [RULE12]
                        aw <= wider(dec.aw, PROTO);
                        dw <= wider(dec.dw, PROTO);
                        dum <= next_dum;
                        addr_go <= 1'b0;
                    end else if (cmd_done) begin
                        // Unknown or refused code: stay off the lines
                        phase <= PH_SKIP;
                    end
                end
                PH_ADDR: begin
                    if (rise) begin
                        addr_go <= 1'b1;
                    end
                    if (samp) begin
                        cnt <= cnt - step;
                    end
                    if (addr_done) begin
                        phase <= (dum == 4'h0) ? PH_DATA : PH_DUMMY;
                    end
                end
                PH_DUMMY: begin
                    if (rise) begin
                        dum <= dum - 4'h1;
                        if (dum == 4'h1) begin
                            phase <= PH_DATA;
                        end
                    end
                end
                PH_DATA: phase <= PH_DATA;
                PH_SKIP: phase <= PH_SKIP;
            endcase
        end
    end

    // Byte pointer wraps by width, so the end of the array rolls to zero
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            idx <= '0;
        end else if (addr_done) begin
            idx <= next_sh[MEM_AW-1:0]; // [RULE5]
        end else if (byte_load) begin
            idx <= idx + 1'b1; // [RULE5] [RULE6]
        end
    end

    // First bit goes out on a falling edge, also at double rate
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            DQ_OUT <= '0;
            DQ_OE <= '0;
            obyte <= '0;
            obits <= '0;
            started <= 1'b0;
        end else if (cs_n_s || phase != PH_DATA) begin
            DQ_OUT <= '0;
            DQ_OE <= '0; // [RULE2] [RULE25]
            obits <= '0;
            started <= 1'b0;
        end else if (out_edge) begin
            started <= 1'b1;
            DQ_OE <= oe_mask(dw); // [RULE25]
            DQ_OUT <= place(src, dw);
            obyte <= src << ostep;
            obits <= ((obits == 4'h0) ? BYTE_BITS : obits) - ostep;
        end
    end

    abort_read_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE2]
        cs_n_s |=> phase == PH_IDLE && DQ_OE == 4'h0)
        else $error("Lines still driven after deselect");

    quiet_lines_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE25]
        phase inside {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_SKIP} |-> DQ_OE == 4'h0)
        else $error("Lines driven outside data phase");

    addr3_len_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE3]
        phase == PH_ADDR && $past(phase) == PH_CMD && !cmd.a4 && !$past(mode4)
        |-> cnt == ADDR3_BITS)
        else $error("Default address length not 24 bits");

    addr4_len_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE15]
        phase == PH_ADDR && $past(phase) == PH_CMD && (cmd.a4 || $past(mode4))
        |-> cnt == ADDR4_BITS)
        else $error("Four-byte address length not 32 bits");

    capture_rise_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE4]
        $past(phase) == PH_ADDR && !dtr && $changed(sh) |-> $past(rise))
        else $error("Address bit taken off a rising edge");

    word_dummy_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE13]
        phase == PH_ADDR && $past(phase) == PH_CMD && cmd.word |-> dum == DUMMY_WORD)
        else $error("Word read dummy count wrong");

    byte_step_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE5]
        byte_load && !(&idx) |=> idx == $past(idx) + 1'b1)
        else $error("Address did not step after a byte");

    wrap_read_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE6]
        byte_load && (&idx) |=> idx == '0)
        else $error("Address did not wrap at the end");

    word_dual_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE14]
        cmd_done && dec.word && PROTO == LW_2 |=> phase == PH_SKIP)
        else $error("Word read accepted in dual protocol");

    dtr_forced_a: assert property (@(posedge MCLK) disable iff (!RESETN) // [RULE12]
        phase == PH_ADDR && $past(phase) == PH_CMD && cmd.dtr |-> dtr)
        else $error("Double-rate opcode ran at single rate");
endmodule

// >>> tb/sfr_host_model.sv
/*
 * Host controller model: drives serial clock, chip-select and the lines, collects bytes.
 * Assumes SCK idles low and the device answers within a few MCLK of each edge.
 */
`timescale 1ns/10ps
module sfr_host_model (
    // Link pins
    output logic sck,
    output logic cs_n,
    output logic [3:0] dq_wire,
    output logic busy,
    // Device drive
    input wire logic [3:0] dq_out,
    input wire logic [3:0] dq_oe
);
    logic [3:0] dq_drv = 4'h5;
    logic [7:0] rx[$];

    // Released lines toggle so a stale level never passes for data
    assign dq_wire = (dq_oe & dq_out) | (~dq_oe & dq_drv);

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        busy = 1'b0;
    end

    // Data set a quarter period before each sampling edge, held a quarter after at double rate, three quarters at single rate
    task automatic shift(input logic [31:0] v, input int n, input int w, input bit ddr);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        for (int i = n - w; i >= 0; i -= w) begin
            #31.25 dq_drv = (~dq_drv & ~m) | (4'(v >> i) & m);
            #31.25 sck = ~sck;
            if (!ddr) begin
                #62.5 sck = 1'b0;
            end
        end
    endtask

    task automatic frame(input logic [7:0] op, input int cw, input bit cddr, input int aw,
                         input int dw, input bit ddr, input int ab, input logic [31:0] a,
                         input int nd, input int nu);
        logic [7:0] b;
        b = 8'h0;
        rx.delete();
        #3.7 busy = 1'b1;
        cs_n = 1'b0;
        #62.5;
        shift(32'(op), 8, cw, cddr);
        shift(a, ab, aw, ddr);
        repeat (nd) begin
            #62.5 sck = 1'b1;
            dq_drv = ~dq_drv;
            #62.5 sck = 1'b0;
        end
        busy = 1'b0;
        for (int u = 1; u <= nu; u++) begin
            #62.5 b = dw == 1 ? {b[6:0], dq_wire[1]} :
                      dw == 2 ? {b[5:0], dq_wire[1:0]} : {b[3:0], dq_wire};
            dq_drv = ~dq_drv;
            if (u % (8 / dw) == 0) begin
                rx.push_back(b);
            end
            if (ddr) begin
                sck = ~sck;
            end else begin
                sck = 1'b1;
                #62.5 sck = 1'b0;
            end
        end
        #62.5 sck = 1'b0;
        cs_n = 1'b1;
        #125;
    endtask
endmodule

// >>> tb/sfr_read_engine_tb_top.sv
/*
 * Self-checking bench for the read engine: fills the array, reads with every opcode
 * through the host model and compares bytes, line enables and address mode.
 * Assumes the host model beside it and the design package.
 */
`timescale 1ns/10ps
module sfr_read_engine_tb_top;
    import sfr_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic sck, cs_n, busy, a4_act;
    logic [3:0] dq_in, dq_out, dq_oe;
    logic [3:0] exp_oe = 4'h0;
    logic [1:0] proto = 2'h0;
    logic dtr_en = 1'b0;
    logic a4_nv = 1'b0;
    logic enter_4b = 1'b0;
    logic exit_4b = 1'b0;
    logic [3:0] dummy_cfg = 4'h0;
    logic fill_en = 1'b0;
    logic [9:0] fill_addr = 10'h0;
    logic [7:0] fill_data = 8'h0;
    integer seed = 32'hdcee;
    int mismatches = 0;
    int checks = 0;
    int cs_hi = 0;
    int mode4 = 0;
    int mem_m[1024];
    int quad_ops[4] = '{5, 11, 16, 10};
    int dual_ops[3] = '{3, 7, 15};
    // Opcode, address lines, data lines, flags {dummy kind[1:0], dtr, four-byte}
    localparam logic [19:0] OPS [21] = '{
        20'h03110, 20'h0b114, 20'h3b124, 20'hbb224, 20'h6b144, 20'heb444,
        20'h0d116, 20'h3d126, 20'hbd226, 20'h6d146, 20'hed446, 20'he7448,
        20'h13111, 20'h0c115, 20'h3c125, 20'hbc225, 20'h6c145, 20'hec445,
        20'h0e117, 20'hbe227, 20'hee447};

    initial begin
        forever #5 mclk = ~mclk;
    end

    sfr_read_engine #(.MEM_AW(10)) DUT (
        .MCLK(mclk), .RESETN(resetn), .SCK(sck), .CS_N(cs_n), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .PROTO(proto), .DTR_ENABLE(dtr_en),
        .ADDR4_NV(a4_nv), .ENTER_4B(enter_4b), .EXIT_4B(exit_4b), .DUMMY_CFG(dummy_cfg),
        .ADDR4_ACTIVE(a4_act), .FILL_EN(fill_en), .FILL_ADDR(fill_addr),
        .FILL_DATA(fill_data));

    sfr_host_model host (.sck(sck), .cs_n(cs_n), .dq_wire(dq_in), .busy(busy),
                         .dq_out(dq_out), .dq_oe(dq_oe));

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_lines(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t line enables %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t address mode %b expected %b", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Lines stay released while the host drives and shortly after deselect
    always @(posedge mclk) begin
        cs_hi <= cs_n ? cs_hi + 1 : 0;
        if (resetn && (cs_hi > 6 || busy)) begin
            check_lines(dq_oe, 4'h0);
        end else if (resetn && !cs_n && dq_oe !== 4'h0) begin
            check_lines(dq_oe, exp_oe);
        end
    end

    task automatic do_reset(input bit nv);
        @(posedge mclk);
        resetn <= 1'b0;
        a4_nv <= nv;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (6) @(posedge mclk);
        mode4 = nv;
        check_flag(a4_act, nv);
    endtask

    task automatic fill;
        integer d;
        for (int i = 0; i < 1024; i++) begin
            d = $random(seed);
            mem_m[i] = d & 255;
            @(posedge mclk);
            fill_en <= 1'b1;
            fill_addr <= 10'(i);
            fill_data <= 8'(d);
        end
        @(posedge mclk);
        fill_en <= 1'b0;
    endtask

    task automatic pulse(input bit en, input bit ex);
        @(posedge mclk);
        enter_4b <= en;
        exit_4b <= ex;
        @(posedge mclk);
        enter_4b <= 1'b0;
        exit_4b <= 1'b0;
        repeat (4) @(posedge mclk);
        mode4 = en;
        check_flag(a4_act, en);
    endtask

    // Address -1 asks for a random one; cut > 0 ends the frame after that many units
    task automatic do_read(input logic [19:0] e, input int p, input bit dten, input int nb,
                           input int cut, input bit ok, input int at);
        int aw, dw, ab, nd, lw;
        logic [31:0] a;
        logic [3:0] dc;
        lw = 1 << p;
        aw = e[11:8] > lw ? e[11:8] : lw;
        dw = e[7:4] > lw ? e[7:4] : lw;
        ab = (e[0] || mode4 != 0) ? 32 : 24;
        a = at < 0 ? 32'($random(seed)) : 32'(at);
        if (e[19:12] == 8'he7) begin
            a[0] = 1'b0;
        end
        dc = 4'($random(seed));
        nd = e[3:2] == 2'h0 ? 0 : e[3:2] == 2'h2 ? 4 : dc == 4'h0 ? 8 : int'(dc);
        exp_oe = !ok ? 4'h0 : dw == 1 ? OE_X1 : dw == 2 ? OE_X2 : OE_X4;
        @(posedge mclk);
        proto <= 2'(p);
        dtr_en <= dten;
        dummy_cfg <= dc;
        repeat (4) @(posedge mclk);
        host.frame(e[19:12], lw, dten, aw, dw, e[1] | dten, ab, a, nd,
                   cut > 0 ? cut : nb * 8 / dw);
        if (ok && cut == 0) begin
            check_byte(8'(host.rx.size()), 8'(nb));
            for (int i = 0; i < nb && i < host.rx.size(); i++) begin
                check_byte(host.rx[i], 8'(mem_m[(a + i) % 1024]));
            end
        end
    endtask

    initial begin
        do_reset(1'b0);
        fill();
        do_read(OPS[0], 0, 0, 4, 0, 1, 1022);
        for (int k = 0; k < 21; k++) begin
            do_read(OPS[k], 0, 0, 1 + k % 4, 0, 1, -1);
        end
        foreach (quad_ops[i]) begin
            do_read(OPS[quad_ops[i]], 2, 0, 2, 0, 1, -1);
        end
        foreach (dual_ops[i]) begin
            do_read(OPS[dual_ops[i]], 1, 0, 2, 0, 1, -1);
        end
        do_read(OPS[1], 0, 1, 2, 0, 1, -1);
        do_read(OPS[5], 2, 1, 2, 0, 1, -1);
        do_read(OPS[11], 1, 0, 2, 0, 0, -1);
        do_read(OPS[11], 0, 1, 2, 0, 0, -1);
        do_read(OPS[0], 0, 0, 3, 11, 1, -1);
        do_read(OPS[2], 0, 0, 2, 0, 1, -1);
        pulse(1'b1, 1'b0);
        do_read(OPS[0], 0, 0, 3, 0, 1, -1);
        do_read(OPS[5], 0, 0, 2, 0, 1, -1);
        pulse(1'b1, 1'b1);
        pulse(1'b0, 1'b1);
        do_read(OPS[12], 0, 0, 2, 0, 1, -1);
        do_read(OPS[1], 0, 0, 2, 0, 1, -1);
        do_reset(1'b1);
        do_read(OPS[0], 0, 0, 2, 0, 1, -1);
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge mclk);
        mismatches++;
        $display("MISMATCH %0t run did not finish", $time);
        complete_run();
    end
endmodule
